//--- ccp_timer_pkg.sv
// Constants for the dual mode capture/compare timer.
// Assumes a single system clock domain.
package ccp_timer_pkg;
    localparam int          CNT_W          = 16;
    localparam logic [15:0] CNT_RESET      = 16'h0000;
    localparam logic [15:0] CNT_MAX        = 16'hffff;
    // Clock source select codes
    localparam logic [1:0]  CLK_SEL_SYS    = 2'h0;
    localparam logic [1:0]  CLK_SEL_PULSE  = 2'h1;
    localparam logic [1:0]  CLK_SEL_EVENT  = 2'h2;
    localparam logic [1:0]  CLK_SEL_STOP   = 2'h3;
    // Flag and control bit positions inside control registers
    localparam int          CR2_EDGE_ONE   = 7;
    localparam int          CR2_EDGE_TWO   = 6;
    localparam int          CR2_CMP_ONE    = 5;
    localparam int          CR1_OVERFLOW   = 3;
    localparam int          CR3_DET_ONE    = 0;
    localparam int          CR3_DET_TWO    = 1;
    localparam int          CR3_MODE       = 7;
    // Pin synchroniser depth
    localparam int          SYNC_STAGES    = 3;
endpackage

//--- ccp_pin_sync.sv
// Three flop pin synchroniser with rising/falling edge pulses.
// Assumes an asynchronous input pin and the system clock.
`timescale 1ns/10ps
`default_nettype none
module ccp_pin_sync (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_resetn,
    // Pin and results
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    import ccp_timer_pkg::*;

    logic [SYNC_STAGES-1:0] sync_q;
    logic [SYNC_STAGES-1:0] sync_d;
    logic                   level_q;
    logic                   level_d;

    always_comb begin
        sync_d  = {sync_q[SYNC_STAGES-2:0], i_pin};
        level_d = level_q;
        // Change counts once stages two and three agree
        if (sync_q[1] == sync_q[2]) begin
            level_d = sync_q[2];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_q  <= '0;
            level_q <= 1'b0;
        end else begin
            sync_q  <= sync_d;
            level_q <= level_d;
        end
    end

    assign o_level = level_q;
    assign o_rise  = level_d & ~level_q;
    assign o_fall  = ~level_d & level_q;
endmodule
`default_nettype wire

//--- ccp_timer.sv
// Dual mode 16-bit capture/compare timer with PWM output.
// Assumes pins are asynchronous; control bits come from a CPU register
// file on the same clock; flag clears are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module ccp_timer (
    // Clock and reset
    input  wire logic                          I_CLK,
    input  wire logic                          I_RESETN,
    // Configuration
    input  wire logic [1:0]                    I_CLK_SEL,
    input  wire logic                          I_CAPTURE_MODE_SELECT,
    input  wire logic                          I_EDGE_ONE_DETECT_ENABLE,
    input  wire logic                          I_EDGE_TWO_DETECT_ENABLE,
    input  wire logic                          I_EDGE_ONE_POLARITY,
    input  wire logic                          I_EDGE_TWO_POLARITY,
    input  wire logic                          I_CMP_ONE_OUT_ENABLE,
    input  wire logic                          I_CMP_TWO_OUT_ENABLE,
    input  wire logic                          I_EDGE_OUT_ENABLE,
    input  wire logic                          I_EDGE_RESET_ENABLE,
    input  wire logic [2:0]                    I_PIN_TIMER_FUNC,
    // Register writes
    input  wire logic                          I_CNT_CLEAR,
    input  wire logic                          I_CMP_WR,
    input  wire logic [ccp_timer_pkg::CNT_W-1:0] I_CMP_DATA,
    input  wire logic                          I_CAPCMP_WR,
    input  wire logic [ccp_timer_pkg::CNT_W-1:0] I_CAPCMP_DATA,
    // Flag clear pulses: edge one, edge/cmp two, cmp one, overflow
    input  wire logic [3:0]                    I_FLAG_CLR,
    // Pins
    input  wire logic                          I_EVENT_CLOCK_PIN,
    input  wire logic                          I_CAPTURE1_RESET_PIN,
    input  wire logic                          I_CAPTURE2_PWM_PIN,
    output logic                               O_CAPTURE2_PWM_PIN,
    output logic                               O_CAPTURE2_PWM_OE_N,
    // State
    output logic [ccp_timer_pkg::CNT_W-1:0]    O_COUNTER,
    output logic [ccp_timer_pkg::CNT_W-1:0]    O_COMPARE,
    output logic [ccp_timer_pkg::CNT_W-1:0]    O_CAPTURE_COMPARE,
    output logic [ccp_timer_pkg::CNT_W-1:0]    O_CAPTURE_TWO,
    output logic [7:0]                         O_CONTROL_REG_ONE,
    output logic [7:0]                         O_CONTROL_REG_TWO,
    output logic                               O_PWM_LEVEL
);
    import ccp_timer_pkg::*;

    logic [CNT_W-1:0] cnt_q,    cnt_d;
    logic [CNT_W-1:0] cmp_q,    cmp_d;
    logic [CNT_W-1:0] capcmp_q, capcmp_d;
    logic [CNT_W-1:0] cap2_q,   cap2_d;
    logic             edge1_flag_q, edge1_flag_d;
    logic             flag2_q,      flag2_d;
    logic             cmp1_flag_q,  cmp1_flag_d;
    logic             ovf_flag_q,   ovf_flag_d;
    logic             pwm_q,        pwm_d;
    logic             evt_level, evt_rise;
    logic             p1_rise,   p1_fall;
    logic             p2_rise,   p2_fall;
    logic             tick;
    logic             edge1_evt;
    logic             edge2_evt;
    logic             cmp1_hit;
    logic             cmp2_hit;
    logic             wrap;
    logic             toggle;

    ccp_pin_sync u_evt_sync (
        .i_clk    (I_CLK),
        .i_resetn (I_RESETN),
        .i_pin    (I_EVENT_CLOCK_PIN),
        .o_level  (evt_level),
        .o_rise   (evt_rise),
        .o_fall   ()
    );
    ccp_pin_sync u_p1_sync (
        .i_clk    (I_CLK),
        .i_resetn (I_RESETN),
        .i_pin    (I_CAPTURE1_RESET_PIN),
        .o_level  (),
        .o_rise   (p1_rise),
        .o_fall   (p1_fall)
    );
    ccp_pin_sync u_p2_sync (
        .i_clk    (I_CLK),
        .i_resetn (I_RESETN),
        .i_pin    (I_CAPTURE2_PWM_PIN),
        .o_level  (),
        .o_rise   (p2_rise),
        .o_fall   (p2_fall)
    );
    // Clock source select, no prescaler stage
    always_comb begin
        case (I_CLK_SEL)
            CLK_SEL_SYS:   tick = 1'b1;
            CLK_SEL_EVENT: tick = evt_rise &
                                  I_PIN_TIMER_FUNC[0];
            CLK_SEL_PULSE: tick = evt_level &
                                  I_PIN_TIMER_FUNC[0];
            CLK_SEL_STOP:  tick = 1'b0;
            default:       tick = 1'b0;
        endcase
    end

    // Pin functions gated by port control selection
    assign edge1_evt = I_PIN_TIMER_FUNC[1] &
        (I_EDGE_ONE_POLARITY ? p1_rise : p1_fall);
    assign edge2_evt = I_PIN_TIMER_FUNC[2] & I_CAPTURE_MODE_SELECT &
        (I_EDGE_TWO_POLARITY ? p2_rise : p2_fall);
    assign cmp1_hit  = (cnt_q == cmp_q);
    assign cmp2_hit  = ~I_CAPTURE_MODE_SELECT &
                       (cnt_q == capcmp_q);
    assign wrap      = tick & (cnt_q == CNT_MAX);

    // PWM toggle sources in compare mode
    assign toggle = ~I_CAPTURE_MODE_SELECT & (
        (cmp1_hit & I_CMP_ONE_OUT_ENABLE) |
        (cmp2_hit & I_CMP_TWO_OUT_ENABLE) |
        (edge1_evt & I_EDGE_OUT_ENABLE));

    always_comb begin
        cnt_d    = cnt_q;
        cmp_d    = cmp_q;
        capcmp_d = capcmp_q;
        cap2_d   = cap2_q;
        pwm_d    = pwm_q ^ toggle;
        if (tick) begin
            cnt_d = cnt_q + 16'h0001;
        end
        if (I_CNT_CLEAR ||
            (~I_CAPTURE_MODE_SELECT & edge1_evt & I_EDGE_RESET_ENABLE)) begin
            cnt_d = CNT_RESET;
        end
        if (I_CMP_WR) begin
            cmp_d = I_CMP_DATA;
        end
        if (I_CAPCMP_WR) begin
            capcmp_d = I_CAPCMP_DATA;
        end
        if (I_CAPTURE_MODE_SELECT && edge1_evt && I_EDGE_ONE_DETECT_ENABLE) begin
            capcmp_d = cnt_q;
        end
        if (edge2_evt && I_EDGE_TWO_DETECT_ENABLE) begin
            cap2_d = cnt_q;
        end
    end

    // Sticky flags, set wins over clear
    always_comb begin
        edge1_flag_d = (edge1_flag_q & ~I_FLAG_CLR[0]) | edge1_evt;
        flag2_d      = (flag2_q & ~I_FLAG_CLR[1]) |
                       edge2_evt | cmp2_hit;
        cmp1_flag_d  = (cmp1_flag_q & ~I_FLAG_CLR[2]) | cmp1_hit;
        ovf_flag_d   = (ovf_flag_q & ~I_FLAG_CLR[3]) | wrap;
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cnt_q        <= CNT_RESET;
            cmp_q        <= CNT_RESET;
            capcmp_q     <= CNT_RESET;
            cap2_q       <= CNT_RESET;
            pwm_q        <= 1'b0;
            edge1_flag_q <= 1'b0;
            flag2_q      <= 1'b0;
            cmp1_flag_q  <= 1'b0;
            ovf_flag_q   <= 1'b0;
        end else begin
            cnt_q        <= cnt_d;
            cmp_q        <= cmp_d;
            capcmp_q     <= capcmp_d;
            cap2_q       <= cap2_d;
            pwm_q        <= pwm_d;
            edge1_flag_q <= edge1_flag_d;
            flag2_q      <= flag2_d;
            cmp1_flag_q  <= cmp1_flag_d;
            ovf_flag_q   <= ovf_flag_d;
        end
    end

    // Outputs
    assign O_COUNTER           = cnt_q;
    assign O_COMPARE           = cmp_q;
    assign O_CAPTURE_COMPARE   = capcmp_q;
    assign O_CAPTURE_TWO       = cap2_q;
    assign O_PWM_LEVEL         = pwm_q;
    assign O_CAPTURE2_PWM_PIN  = pwm_q;
    assign O_CAPTURE2_PWM_OE_N = ~(I_PIN_TIMER_FUNC[2] &
                                   ~I_CAPTURE_MODE_SELECT);
    always_comb begin
        O_CONTROL_REG_ONE               = 8'h00;
        O_CONTROL_REG_ONE[CR1_OVERFLOW] = ovf_flag_q;
        O_CONTROL_REG_TWO               = 8'h00;
        O_CONTROL_REG_TWO[CR2_EDGE_ONE] = edge1_flag_q;
        O_CONTROL_REG_TWO[CR2_EDGE_TWO] = flag2_q;
        O_CONTROL_REG_TWO[CR2_CMP_ONE]  = cmp1_flag_q;
    end

    // Checks
    property p_overflow_flag;
        @(posedge I_CLK) disable iff (!I_RESETN)
        wrap |=> ovf_flag_q;
    endproperty
    a_overflow_flag: assert property (p_overflow_flag)
        else $error("overflow flag not set on wrap");

    property p_count_step;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (tick && !I_CNT_CLEAR && !edge1_evt) |=> cnt_q == $past(cnt_q) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step by one");

    property p_stop_hold;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (I_CLK_SEL == CLK_SEL_STOP && !I_CNT_CLEAR && !edge1_evt)
            |=> cnt_q == $past(cnt_q);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("counter moved while stopped");

    property p_cmp1_flag;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (cnt_q == cmp_q) |=> cmp1_flag_q;
    endproperty
    a_cmp1_flag: assert property (p_cmp1_flag)
        else $error("compare one flag missed");

    property p_capture_one;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (I_CAPTURE_MODE_SELECT && edge1_evt && I_EDGE_ONE_DETECT_ENABLE)
            |=> capcmp_q == $past(cnt_q);
    endproperty
    a_capture_one: assert property (p_capture_one)
        else $error("capture one value wrong");

    property p_capture_two;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (edge2_evt && I_EDGE_TWO_DETECT_ENABLE) |=> cap2_q == $past(cnt_q);
    endproperty
    a_capture_two: assert property (p_capture_two)
        else $error("capture two value wrong");

    property p_edge_one_flag;
        @(posedge I_CLK) disable iff (!I_RESETN)
        edge1_evt |=> edge1_flag_q;
    endproperty
    a_edge_one_flag: assert property (p_edge_one_flag)
        else $error("edge one flag missed");

    property p_pwm_hold_capture;
        @(posedge I_CLK) disable iff (!I_RESETN)
        I_CAPTURE_MODE_SELECT |=> pwm_q == $past(pwm_q);
    endproperty
    a_pwm_hold_capture: assert property (p_pwm_hold_capture)
        else $error("pwm toggled in capture mode");

    property p_sticky;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (ovf_flag_q && !I_FLAG_CLR[3]) |=> ovf_flag_q;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without clear");

    property p_cmp2_flag;
        @(posedge I_CLK) disable iff (!I_RESETN)
        cmp2_hit |=> flag2_q;
    endproperty
    a_cmp2_flag: assert property (p_cmp2_flag)
        else $error("compare two flag missed");

    property p_edge_two_flag;
        @(posedge I_CLK) disable iff (!I_RESETN)
        edge2_evt |=> flag2_q;
    endproperty
    a_edge_two_flag: assert property (p_edge_two_flag)
        else $error("edge two flag missed");

    property p_edge_reset;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (!I_CAPTURE_MODE_SELECT && edge1_evt && I_EDGE_RESET_ENABLE)
            |=> cnt_q == CNT_RESET;
    endproperty
    a_edge_reset: assert property (p_edge_reset)
        else $error("edge did not reset counter");

    property p_pwm_toggle;
        @(posedge I_CLK) disable iff (!I_RESETN)
        toggle |=> pwm_q != $past(pwm_q);
    endproperty
    a_pwm_toggle: assert property (p_pwm_toggle)
        else $error("pwm did not toggle");
endmodule
`default_nettype wire

//--- ccp_pin_model.sv
// Far side model: event source, first input pin and the shared pin two.
// Assumes the timer's pin two enable is low while the timer drives it.
`timescale 1ns/10ps
`default_nettype none
module ccp_pin_model (
    // Clock
    input  wire logic i_clk,
    // Timer pin two drive
    input  wire logic i_pwm,
    input  wire logic i_pwm_oe_n,
    // Pin levels seen by the timer
    output logic      o_event,
    output logic      o_pin1,
    output logic      o_pin2
);
    logic p2_drv;
    initial begin
        {o_event, o_pin1, p2_drv} = 3'h0;
    end
    // Shared pin: the timer's drive wins while its enable is low
    assign o_pin2 = i_pwm_oe_n ? p2_drv : i_pwm;
    // Toggles one pin n times, never faster than half the clock
    task automatic toggle(input int sel, input int n, input int hold);
        repeat (n) begin
            repeat ((hold < 2) ? 2 : hold) @(posedge i_clk);
            #1;
            case (sel)
                0: o_event = ~o_event;
                1: o_pin1 = ~o_pin1;
                default: p2_drv = ~p2_drv;
            endcase
        end
    endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the dual mode capture/compare timer.
// Assumes the pin model drives all three timer pins.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import ccp_timer_pkg::*;
    logic        I_CLK = 1'b0;
    logic        I_RESETN, I_CAPTURE_MODE_SELECT, I_CNT_CLEAR;
    logic        I_EDGE_ONE_DETECT_ENABLE, I_EDGE_TWO_DETECT_ENABLE;
    logic        I_EDGE_ONE_POLARITY, I_EDGE_TWO_POLARITY;
    logic        I_CMP_ONE_OUT_ENABLE, I_CMP_TWO_OUT_ENABLE;
    logic        I_EDGE_OUT_ENABLE, I_EDGE_RESET_ENABLE;
    logic        I_CMP_WR, I_CAPCMP_WR, O_PWM_LEVEL;
    logic [1:0]  I_CLK_SEL;
    logic [2:0]  I_PIN_TIMER_FUNC;
    logic [3:0]  I_FLAG_CLR;
    logic [15:0] I_CMP_DATA, I_CAPCMP_DATA;
    logic        I_EVENT_CLOCK_PIN, I_CAPTURE1_RESET_PIN;
    logic        I_CAPTURE2_PWM_PIN, O_CAPTURE2_PWM_PIN, O_CAPTURE2_PWM_OE_N;
    logic [15:0] O_COUNTER, O_COMPARE, O_CAPTURE_COMPARE, O_CAPTURE_TWO;
    logic [7:0]  O_CONTROL_REG_ONE, O_CONTROL_REG_TWO;
    int          fails = 0;
    int          n_compared = 0;
    int          cycles = 0;

    ccp_timer DUT (.*);
    ccp_pin_model SRC (
        .i_clk      (I_CLK),
        .i_pwm      (O_CAPTURE2_PWM_PIN),
        .i_pwm_oe_n (O_CAPTURE2_PWM_OE_N),
        .o_event    (I_EVENT_CLOCK_PIN),
        .o_pin1     (I_CAPTURE1_RESET_PIN),
        .o_pin2     (I_CAPTURE2_PWM_PIN)
    );

    always #4 I_CLK = ~I_CLK;

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge I_CLK) begin
        cycles++;
        if (cycles >= 90000) begin
            fails++;
            final_report();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge I_CLK);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic flag(input string what, input logic exp, input logic got);
        chk(what, {15'h0, exp}, {15'h0, got});
    endtask
    task automatic clr_flags();
        I_FLAG_CLR = 4'hf;
        step(1);
        I_FLAG_CLR = 4'h0;
    endtask
    task automatic clr_cnt();
        I_CNT_CLEAR = 1'b1;
        step(1);
        I_CNT_CLEAR = 1'b0;
    endtask
    // Runs the counter from the system clock for n edges, then stops it
    task automatic run_sys(input int n);
        I_CLK_SEL = CLK_SEL_SYS;
        step(n);
        I_CLK_SEL = CLK_SEL_STOP;
    endtask

    task automatic t_sources();
        chk("reset counter", 16'h0000, O_COUNTER);
        chk("reset ctl one", 16'h0000, {8'h0, O_CONTROL_REG_ONE});
        clr_flags();
        run_sys(10);
        chk("sys count", 16'h000a, O_COUNTER);
        step(5);
        chk("stopped hold", 16'h000a, O_COUNTER);
        clr_cnt();
        I_CLK_SEL = CLK_SEL_EVENT;
        SRC.toggle(0, 12, 2);
        step(6);
        chk("event count", 16'h0006, O_COUNTER);
        clr_cnt();
        I_CLK_SEL = CLK_SEL_PULSE;
        SRC.toggle(0, 2, 20);
        step(6);
        chk("pulse count", 16'h0014, O_COUNTER);
        I_CLK_SEL = CLK_SEL_STOP;
    endtask

    task automatic t_overflow();
        clr_cnt();
        clr_flags();
        run_sys(65535);
        chk("count top", CNT_MAX, O_COUNTER);
        flag("early overflow", 1'b0, O_CONTROL_REG_ONE[3]);
        run_sys(2);
        chk("wrapped", 16'h0001, O_COUNTER);
        flag("overflow", 1'b1, O_CONTROL_REG_ONE[3]);
        clr_flags();
        flag("overflow cleared", 1'b0, O_CONTROL_REG_ONE[3]);
        chk("count kept", 16'h0001, O_COUNTER);
    endtask

    task automatic t_compare();
        I_CMP_WR = 1'b1;
        I_CMP_DATA = 16'h0005;
        I_CAPCMP_WR = 1'b1;
        I_CAPCMP_DATA = 16'h000c;
        step(1);
        chk("compare reg", 16'h0005, O_COMPARE);
        {I_CMP_WR, I_CAPCMP_WR} = 2'h0;
        {I_CMP_ONE_OUT_ENABLE, I_CMP_TWO_OUT_ENABLE} = 2'h3;
        clr_cnt();
        clr_flags();
        flag("pin driven", 1'b0, O_CAPTURE2_PWM_OE_N);
        run_sys(5);
        flag("cmp one early", 1'b0, O_CONTROL_REG_TWO[5]);
        run_sys(1);
        flag("cmp one", 1'b1, O_CONTROL_REG_TWO[5]);
        flag("pwm set", 1'b1, O_PWM_LEVEL);
        run_sys(6);
        flag("cmp two early", 1'b0, O_CONTROL_REG_TWO[6]);
        flag("cmp one sticky", 1'b1, O_CONTROL_REG_TWO[5]);
        run_sys(1);
        flag("cmp two", 1'b1, O_CONTROL_REG_TWO[6]);
        flag("pwm clear", 1'b0, O_CAPTURE2_PWM_PIN);
        clr_flags();
        chk("flags cleared", 16'h0000, {8'h0, O_CONTROL_REG_TWO});
        chk("count kept", 16'h000d, O_COUNTER);
        {I_EDGE_OUT_ENABLE, I_EDGE_RESET_ENABLE} = 2'h3;
        I_EDGE_ONE_DETECT_ENABLE = 1'b1;
        SRC.toggle(1, 1, 2);
        step(6);
        flag("edge one", 1'b1, O_CONTROL_REG_TWO[7]);
        chk("edge reset", 16'h0000, O_COUNTER);
        flag("edge toggles", 1'b1, O_PWM_LEVEL);
        chk("no capture", 16'h000c, O_CAPTURE_COMPARE);
        SRC.toggle(1, 1, 2);
        step(6);
        flag("falling ignored", 1'b1, O_PWM_LEVEL);
        clr_flags();
        I_PIN_TIMER_FUNC = 3'h5;
        SRC.toggle(1, 2, 3);
        step(6);
        flag("gpio pin", 1'b0, O_CONTROL_REG_TWO[7]);
        I_PIN_TIMER_FUNC = 3'h7;
    endtask

    task automatic t_capture();
        I_CAPTURE_MODE_SELECT = 1'b1;
        I_EDGE_TWO_DETECT_ENABLE = 1'b1;
        clr_cnt();
        clr_flags();
        step(1);
        flag("pin released", 1'b1, O_CAPTURE2_PWM_OE_N);
        run_sys(7);
        flag("cmp in capture", 1'b1, O_CONTROL_REG_TWO[5]);
        SRC.toggle(1, 1, 2);
        SRC.toggle(2, 1, 2);
        step(6);
        flag("edge one", 1'b1, O_CONTROL_REG_TWO[7]);
        chk("capture one", 16'h0007, O_CAPTURE_COMPARE);
        flag("edge two", 1'b1, O_CONTROL_REG_TWO[6]);
        chk("capture two", 16'h0007, O_CAPTURE_TWO);
        clr_flags();
        chk("capture kept", 16'h0007, O_CAPTURE_TWO);
        I_EDGE_ONE_DETECT_ENABLE = 1'b0;
        run_sys(3);
        SRC.toggle(1, 2, 2);
        step(6);
        flag("edge one again", 1'b1, O_CONTROL_REG_TWO[7]);
        chk("detect off", 16'h0007, O_CAPTURE_COMPARE);
        I_EDGE_TWO_POLARITY = 1'b0;
        SRC.toggle(2, 1, 2);
        step(6);
        flag("edge two fall", 1'b1, O_CONTROL_REG_TWO[6]);
        chk("capture two fall", 16'h000a, O_CAPTURE_TWO);
    endtask

    initial begin
        I_RESETN = 1'b0;
        I_CLK_SEL = CLK_SEL_STOP;
        I_PIN_TIMER_FUNC = 3'h7;
        {I_EDGE_ONE_POLARITY, I_EDGE_TWO_POLARITY} = 2'h3;
        {I_CAPTURE_MODE_SELECT, I_EDGE_ONE_DETECT_ENABLE} = 2'h0;
        {I_EDGE_TWO_DETECT_ENABLE, I_CMP_ONE_OUT_ENABLE} = 2'h0;
        {I_CMP_TWO_OUT_ENABLE, I_EDGE_OUT_ENABLE} = 2'h0;
        {I_EDGE_RESET_ENABLE, I_CNT_CLEAR, I_CMP_WR, I_CAPCMP_WR} = 4'h0;
        {I_CMP_DATA, I_CAPCMP_DATA, I_FLAG_CLR} = 36'h0;
        step(2);
        I_RESETN = 1'b1;
        step(1);
        t_sources();
        t_overflow();
        t_compare();
        t_capture();
        final_report();
    end
endmodule
`default_nettype wire
